/* File: eiw_map.vh */
// Constants for the encoder input word table: offsets, codes, timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef EIW_MAP_VH
`define EIW_MAP_VH

// ----------------------------------------
// Word offsets from the table base
// ----------------------------------------
`define EIW_OFF_ERROR      4'h0
`define EIW_OFF_RATE       4'h1
`define EIW_OFF_GRAY       4'h2
`define EIW_OFF_BINARY     4'h3
`define EIW_OFF_TOTAL_LO   4'h4
`define EIW_OFF_TOTAL_HI   4'h5
`define EIW_OFF_CAPTURE0   4'h6
`define EIW_OFF_CAPTURE1   4'h7
`define EIW_OFF_CAPTURE2   4'h8
`define EIW_OFF_CAPTURE3   4'h9
`define EIW_OFF_TIMER1     4'ha
`define EIW_OFF_TIMER2     4'hb
`define EIW_OFF_COMPARE    4'hc
`define EIW_OFF_LAST       4'he

// ----------------------------------------
// Error codes
// ----------------------------------------
`define EIW_ERR_NONE       16'h0000
`define EIW_ERR_POS_OFFSET 16'h0010
`define EIW_ERR_ON_PRESET  8'h11
`define EIW_ERR_OFF_PRESET 8'h12
`define EIW_ERR_HOME_POS   16'h0015
`define EIW_ERR_PRELOAD    16'h0016
`define EIW_ERR_HOME_FSM   16'h001c
`define EIW_ERR_ABS_INPUT  16'h001d
`define EIW_ERR_QUAD_SEQ   16'h001e

// ----------------------------------------
// Timing
// ----------------------------------------
`define EIW_CLK_PERIOD_NS  4
`define EIW_MS_IN_NS       1000000
`define EIW_TIMEBASE_MS    16'h03e8
`define EIW_SYNC_WARM      2'h3
`define EIW_ZERO16         16'h0000
`define EIW_ZERO32         32'h0000_0000

`endif

/* File: eiw_sync.v */
// Two-flip-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps

module eiw_sync #(
  parameter W = 1
) (
  input  wire         core_clk,  // Core clock
  input  wire         resetn,    // Async reset, active low
  input  wire [W-1:0] pin_d,     // Asynchronous pin levels
  output wire [W-1:0] sync_q     // Levels in the core clock domain
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stable_q;

  // ----------------------------------------
  // Synchroniser pair
  // ----------------------------------------
  // First stage is read only by the second.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= {W{1'b0}};
      stable_q <= {W{1'b0}};
    end else begin
      meta_q   <= pin_d;
      stable_q <= meta_q;
    end
  end

  assign sync_q = stable_q;

endmodule // eiw_sync

/* File: eiw_rate.v */
// Millisecond tick and counts-per-timebase measurement.
// Assumes cnt_evt is a one-cycle pulse from logic on core_clk.
`timescale 1ns/1ps
`include "eiw_map.vh"

module eiw_rate #(
  parameter CLK_PER_MS = 250000
) (
  input  wire        core_clk,   // Core clock
  input  wire        resetn,     // Async reset, active low
  input  wire        cnt_evt,    // One input count this cycle
  input  wire [15:0] tb_ms,      // Timebase in ms, zero selects default
  output reg         ms_tick_q,  // One-cycle pulse each ms
  output reg  [15:0] rate_q      // Counts in last completed interval
);

  reg [31:0] pre_q;
  reg [15:0] ms_q;
  reg [15:0] acc_q;
  wire [15:0] tb_len = (tb_ms == `EIW_ZERO16) ? `EIW_TIMEBASE_MS : tb_ms;
  wire        pre_end = (pre_q == CLK_PER_MS - 1);
  wire        tb_end  = pre_end && (ms_q == tb_len - 16'h0001);

  // ----------------------------------------
  // Prescaler and interval counter
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q     <= `EIW_ZERO32;
      ms_q      <= `EIW_ZERO16;
      acc_q     <= `EIW_ZERO16;
      rate_q    <= `EIW_ZERO16;
      ms_tick_q <= 1'b0;
    end else begin
      pre_q     <= pre_end ? `EIW_ZERO32 : pre_q + 32'h0000_0001;
      ms_tick_q <= pre_end;
      if (tb_end) begin
        ms_q   <= `EIW_ZERO16;
        rate_q <= acc_q + {15'h0000, cnt_evt};
        acc_q  <= `EIW_ZERO16;
      end else begin
        if (pre_end)
          ms_q <= ms_q + 16'h0001;
        acc_q <= acc_q + {15'h0000, cnt_evt};
      end
    end
  end

endmodule // eiw_rate

/* File: eiw_table.v */
// Encoder input word table: keeps the status and measurement words and
// sends the whole table, one word a cycle, at every sweep.
// Assumes config, error requests and clear commands come from core_clk
// logic; encoder, marker, fault and strobe pins are asynchronous.
`timescale 1ns/1ps
`include "eiw_map.vh"

module eiw_table #(
  parameter CLK_PER_MS = `EIW_MS_IN_NS / `EIW_CLK_PERIOD_NS,
  parameter ENC_W      = 16
) (
  input  wire             core_clk,         // Core clock, 250 MHz
  input  wire             resetn,           // Async reset, active low
  input  wire             sweep_start,      // Pulse: begin table transfer
  input  wire [15:0]      cfg_base_addr,    // Table base word address
  input  wire             quadrature_counter_mode, // 1 quadrature, 0 absolute
  input  wire [15:0]      cfg_timebase_ms,  // Timebase, 0 gives default
  input  wire [ENC_W-1:0] enc_gray_pin,     // Parallel Gray code pins
  input  wire             quad_a_pin,       // Quadrature phase A pin
  input  wire             quad_b_pin,       // Quadrature phase B pin
  input  wire             home_marker_pin,  // Home marker pin
  input  wire             abs_fault_pin,    // Absolute encoder fault pin
  input  wire [3:0]       strobe_pin,       // Strobe pins, inputs 9-12
  input  wire [3:0]       strobe_clear,     // Pulse: re-arm strobe capture
  input  wire             preload_cmd,      // Pulse: load total count
  input  wire [31:0]      preload_value,    // Total count load value
  input  wire             offset_bad,       // Pulse: position offset range
  input  wire             on_preset_bad,    // Pulse: on-preset range
  input  wire             off_preset_bad,   // Pulse: off-preset range
  input  wire [7:0]       preset_num,       // Number of offending preset
  input  wire             home_pos_bad,     // Pulse: home position range
  input  wire             preload_pos_bad,  // Pulse: preload position range
  input  wire             home_fsm_bad,     // Pulse: homing FSM invalid
  input  wire             error_clear,      // Pulse: controller clears error
  input  wire [15:0]      compare_states,   // Comparators 17-32 on/off
  output reg              word_valid_q,     // Word on the output this cycle
  output reg  [15:0]      word_addr_q,      // Word address, base plus offset
  output reg  [15:0]      word_data_q,      // Word contents
  output reg              sweep_busy_q,     // Transfer in progress
  output reg              error_flag_q      // Error pending
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [ENC_W-1:0] gray_to_bin;
    input [ENC_W-1:0] g;
    integer i;
    begin
      gray_to_bin[ENC_W-1] = g[ENC_W-1];
      for (i = ENC_W - 2; i >= 0; i = i - 1) begin
        gray_to_bin[i] = gray_to_bin[i+1] ^ g[i];
      end
    end
  endfunction

  function [15:0] word_at;
    input [15:0] base;
    input [3:0]  off;
    begin
      word_at = base + {12'h000, off};
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [ENC_W-1:0] gray_s;
  wire [7:0]       misc_s;

  eiw_sync #(.W(ENC_W)) u_sync_gray (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_d    (enc_gray_pin),
    .sync_q   (gray_s)
  );

  eiw_sync #(.W(8)) u_sync_misc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_d    ({strobe_pin, abs_fault_pin, home_marker_pin, quad_b_pin, quad_a_pin}),
    .sync_q   (misc_s)
  );

  wire       a_s      = misc_s[0];
  wire       b_s      = misc_s[1];
  wire       marker_s = misc_s[2];
  wire       fault_s  = misc_s[3];
  wire [3:0] strobe_s = misc_s[7:4];

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  reg        a_q;
  reg        b_q;
  reg        marker_q;
  reg [3:0]  strobe_q;
  reg [15:0] bin_prev_q;
  reg [1:0]  warm_q;
  wire [15:0] abs_bin;
  assign abs_bin = gray_to_bin(gray_s);
  // No edges until the synchronisers hold real pin levels: a pin
  // already high at reset must not look like an edge or a fault
  wire       live = (warm_q == `EIW_SYNC_WARM);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      warm_q     <= 2'h0;
      a_q        <= 1'b0;
      b_q        <= 1'b0;
      marker_q   <= 1'b0;
      strobe_q   <= 4'h0;
      bin_prev_q <= `EIW_ZERO16;
    end else begin
      if (!live)
        warm_q <= warm_q + 2'h1;
      a_q        <= a_s;
      b_q        <= b_s;
      marker_q   <= marker_s;
      strobe_q   <= strobe_s;
      bin_prev_q <= abs_bin;
    end
  end

  // Quadrature decode: one change is a count, both at once is a fault
  wire a_chg     = live && (a_s ^ a_q);
  wire b_chg     = live && (b_s ^ b_q);
  wire quad_step = quadrature_counter_mode && (a_chg ^ b_chg);
  wire quad_up   = a_q ^ b_s;
  wire quad_err  = quadrature_counter_mode && a_chg && b_chg;
  wire home_hit  = live && quadrature_counter_mode && marker_s && !marker_q;
  wire abs_step  = live && !quadrature_counter_mode && (abs_bin != bin_prev_q);
  wire abs_err   = !quadrature_counter_mode && fault_s;
  wire cnt_evt   = quad_step || abs_step;
  wire [3:0] strobe_rise = strobe_s & ~strobe_q & {4{live}};

  // ----------------------------------------
  // Input counter and total count
  // ----------------------------------------
  reg [15:0] quad_cnt_q;
  reg [31:0] total_q;
  wire [31:0] abs_delta = {{16{1'b0}}, abs_bin} - {{16{1'b0}}, bin_prev_q};

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      quad_cnt_q <= `EIW_ZERO16;
      total_q    <= `EIW_ZERO32;
    end else begin
      if (home_hit)
        quad_cnt_q <= `EIW_ZERO16;
      else if (quad_step)
        quad_cnt_q <= quad_up ? quad_cnt_q + 16'h0001 : quad_cnt_q - 16'h0001;
      // Command preload wins over counting in the same cycle
      if (preload_cmd)
        total_q <= preload_value;
      else if (home_hit)
        total_q <= `EIW_ZERO32;
      else if (quad_step)
        total_q <= quad_up ? total_q + 32'h0000_0001 : total_q - 32'h0000_0001;
      else if (abs_step)
        total_q <= {{16{abs_delta[15]}}, abs_delta[15:0]} + total_q;
    end
  end

  // Gray word only means something in absolute mode
  wire [15:0] gray_word = quadrature_counter_mode ? `EIW_ZERO16 : gray_s;
  wire [15:0] bin_word  = quadrature_counter_mode ? quad_cnt_q : abs_bin;

  // ----------------------------------------
  // Counts per timebase
  // ----------------------------------------
  wire        ms_tick;
  wire [15:0] rate_word;

  eiw_rate #(.CLK_PER_MS(CLK_PER_MS)) u_rate (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .cnt_evt   (cnt_evt),
    .tb_ms     (cfg_timebase_ms),
    .ms_tick_q (ms_tick),
    .rate_q    (rate_word)
  );

  // ----------------------------------------
  // Strobe captures and start/stop timers
  // ----------------------------------------
  reg [15:0] cap_q [0:3];
  reg [3:0]  cap_lock_q;
  reg [15:0] run1_q;
  reg [15:0] run2_q;
  reg [15:0] timer1_q;
  reg [15:0] timer2_q;
  integer k;

  // Capture locks until cleared; a strobe in the clear cycle is kept
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < 4; k = k + 1) begin
        cap_q[k] <= `EIW_ZERO16;
      end
      cap_lock_q <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (strobe_rise[k] && (!cap_lock_q[k] || strobe_clear[k])) begin
          cap_q[k]      <= bin_word;
          cap_lock_q[k] <= 1'b1;
        end else if (strobe_clear[k]) begin
          cap_lock_q[k] <= 1'b0;
        end
      end
    end
  end

  // Time in ms between successive rising edges of input 10, and of input 12
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run1_q   <= `EIW_ZERO16;
      run2_q   <= `EIW_ZERO16;
      timer1_q <= `EIW_ZERO16;
      timer2_q <= `EIW_ZERO16;
    end else begin
      if (strobe_rise[1]) begin
        timer1_q <= run1_q;
        run1_q   <= `EIW_ZERO16;
      end else if (ms_tick && run1_q != 16'hffff) begin
        run1_q <= run1_q + 16'h0001;
      end
      if (strobe_rise[3]) begin
        timer2_q <= run2_q;
        run2_q   <= `EIW_ZERO16;
      end else if (ms_tick && run2_q != 16'hffff) begin
        run2_q <= run2_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // First-error latch
  // ----------------------------------------
  reg [15:0] err_code_q;
  reg [15:0] new_code;
  reg        new_err;

  // Fixed priority among errors raised in the same cycle
  always @* begin
    new_err  = 1'b1;
    new_code = `EIW_ERR_NONE;
    if (offset_bad && !quadrature_counter_mode)
      new_code = `EIW_ERR_POS_OFFSET;
    else if (on_preset_bad)
      new_code = {preset_num, `EIW_ERR_ON_PRESET};
    else if (off_preset_bad)
      new_code = {preset_num, `EIW_ERR_OFF_PRESET};
    else if (home_pos_bad && quadrature_counter_mode)
      new_code = `EIW_ERR_HOME_POS;
    else if (preload_pos_bad && quadrature_counter_mode)
      new_code = `EIW_ERR_PRELOAD;
    else if (quad_err)
      new_code = `EIW_ERR_QUAD_SEQ;
    else if (home_fsm_bad && quadrature_counter_mode)
      new_code = `EIW_ERR_HOME_FSM;
    else if (abs_err)
      new_code = `EIW_ERR_ABS_INPUT;
    else
      new_err = 1'b0;
  end

  // Later errors are held off while one is pending; set beats clear
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_code_q   <= `EIW_ERR_NONE;
      error_flag_q <= 1'b0;
    end else begin
      if (new_err && (!error_flag_q || error_clear)) begin
        err_code_q   <= new_code;
        error_flag_q <= 1'b1;
      end else if (error_clear) begin
        err_code_q   <= `EIW_ERR_NONE;
        error_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sweep transfer
  // ----------------------------------------
  reg [3:0]  off_q;
  reg [15:0] total_hi_q;
  reg [15:0] word_mux;

  always @* begin
    case (off_q)
      `EIW_OFF_ERROR:    word_mux = err_code_q;
      `EIW_OFF_RATE:     word_mux = rate_word;
      `EIW_OFF_GRAY:     word_mux = gray_word;
      `EIW_OFF_BINARY:   word_mux = bin_word;
      `EIW_OFF_TOTAL_LO: word_mux = total_q[15:0];
      `EIW_OFF_TOTAL_HI: word_mux = total_hi_q;
      `EIW_OFF_CAPTURE0: word_mux = cap_q[0];
      `EIW_OFF_CAPTURE1: word_mux = cap_q[1];
      `EIW_OFF_CAPTURE2: word_mux = cap_q[2];
      `EIW_OFF_CAPTURE3: word_mux = cap_q[3];
      `EIW_OFF_TIMER1:   word_mux = timer1_q;
      `EIW_OFF_TIMER2:   word_mux = timer2_q;
      `EIW_OFF_COMPARE:  word_mux = compare_states;
      default:           word_mux = `EIW_ZERO16;
    endcase
  end

  // High half is taken with the low half so the pair stays coherent
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      off_q        <= 4'h0;
      total_hi_q   <= `EIW_ZERO16;
      sweep_busy_q <= 1'b0;
      word_valid_q <= 1'b0;
      word_addr_q  <= `EIW_ZERO16;
      word_data_q  <= `EIW_ZERO16;
    end else begin
      word_valid_q <= sweep_busy_q;
      word_addr_q  <= word_at(cfg_base_addr, off_q);
      word_data_q  <= word_mux;
      if (sweep_busy_q && off_q == `EIW_OFF_TOTAL_LO)
        total_hi_q <= total_q[31:16];
      if (!sweep_busy_q) begin
        off_q <= 4'h0;
        if (sweep_start)
          sweep_busy_q <= 1'b1;
      end else if (off_q == `EIW_OFF_LAST) begin
        sweep_busy_q <= 1'b0;
        off_q        <= 4'h0;
      end else begin
        off_q <= off_q + 4'h1;
      end
    end
  end

endmodule // eiw_table

/* File: eiw_table_properties.sv */
// Concurrent checks on the encoder input word table ports.
// Assumes cfg_base_addr holds still while a sweep runs.
`timescale 1ns/1ps
module eiw_table_properties #(
  parameter CLK_PER_MS = 250000,
  parameter ENC_W      = 16
) (
  input logic        core_clk,                // Core clock
  input logic        resetn,                  // Async reset, active low
  input logic        sweep_start,             // Sweep request
  input logic [15:0] cfg_base_addr,           // Table base
  input logic        quadrature_counter_mode, // Mode select
  input logic        on_preset_bad,           // On-preset error pulse
  input logic        error_clear,             // Error clear pulse
  input logic [15:0] compare_states,          // Comparator states
  input logic        word_valid_q,            // Word strobe
  input logic [15:0] word_addr_q,             // Word address
  input logic [15:0] word_data_q,             // Word contents
  input logic        sweep_busy_q,            // Sweep running
  input logic        error_flag_q             // Error pending
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_take;
    sweep_start && !sweep_busy_q;
  endsequence
  sequence s_first;
    sweep_busy_q ##1 (word_valid_q && word_addr_q == cfg_base_addr);
  endsequence
  sequence s_burst;
    word_valid_q [*8] ##1 word_valid_q [*7] ##1 !word_valid_q;
  endsequence

  sweep_answer_a: assert property (s_take |=> s_first)
    else $error("sweep not answered in time");
  sweep_length_a: assert property ($rose(word_valid_q) |-> s_burst)
    else $error("sweep not fifteen words");
  sweep_idle_a: assert property (!sweep_busy_q && !sweep_start |=> !sweep_busy_q)
    else $error("sweep began unrequested");
  addr_step_a: assert property (word_valid_q && $past(word_valid_q)
    |-> word_addr_q == $past(word_addr_q) + 16'h1)
    else $error("word address not consecutive");
  reserved_zero_a: assert property (word_valid_q && word_addr_q - cfg_base_addr > 16'hc
    |-> word_data_q == 16'h0000)
    else $error("reserved word not zero");
  error_zero_a: assert property (word_valid_q && word_addr_q == cfg_base_addr
    && !$past(error_flag_q) |-> word_data_q == 16'h0000)
    else $error("error word nonzero with no error");
  error_hold_a: assert property (error_flag_q && !error_clear |=> error_flag_q)
    else $error("error dropped without clear");
  error_set_a: assert property (on_preset_bad && (!error_flag_q || error_clear)
    |=> error_flag_q)
    else $error("preset error not flagged");
  gray_quad_a: assert property (word_valid_q && word_addr_q == cfg_base_addr + 16'h2
    && quadrature_counter_mode && $past(quadrature_counter_mode, 2)
    |-> word_data_q == 16'h0000)
    else $error("gray word set in quadrature mode");
  compare_word_a: assert property (word_valid_q && word_addr_q == cfg_base_addr + 16'hc
    |-> word_data_q == $past(compare_states))
    else $error("comparator word wrong");
endmodule // eiw_table_properties

bind eiw_table eiw_table_properties #(
  .CLK_PER_MS(CLK_PER_MS),
  .ENC_W(ENC_W)
) u_eiw_table_properties (
  .core_clk(core_clk), .resetn(resetn), .sweep_start(sweep_start),
  .cfg_base_addr(cfg_base_addr), .quadrature_counter_mode(quadrature_counter_mode),
  .on_preset_bad(on_preset_bad), .error_clear(error_clear),
  .compare_states(compare_states), .word_valid_q(word_valid_q),
  .word_addr_q(word_addr_q), .word_data_q(word_data_q),
  .sweep_busy_q(sweep_busy_q), .error_flag_q(error_flag_q)
);

/* File: eiw_cpu_model.sv */
// Controller side: files each swept word by its offset from the base.
// Assumes one word a cycle while word_valid_q is high.
`timescale 1ns/1ps
module eiw_cpu_model (
  input  logic        core_clk,      // Core clock
  input  logic        resetn,        // Async reset, active low
  input  logic [15:0] base,          // Configured table base
  input  logic        word_valid_q,  // Word strobe
  input  logic [15:0] word_addr_q,   // Word address
  input  logic [15:0] word_data_q,   // Word contents
  output logic [15:0] words [0:14],  // Last sweep by offset
  output logic [4:0]  n_words,       // Words in last sweep
  output logic        addr_bad       // Word out of its slot
);
  logic        prev_q;
  logic [15:0] off;
  logic [4:0]  slot;
  // Never requests: the table arrives unasked
  assign off  = word_addr_q - base;
  assign slot = prev_q ? n_words : 5'h0;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q   <= 1'b0;
      n_words  <= 5'h0;
      addr_bad <= 1'b0;
    end else begin
      prev_q <= word_valid_q;
      if (word_valid_q) begin
        n_words <= slot + 5'h1;
        if (off != {11'h0, slot}) begin
          addr_bad <= 1'b1;
        end
        if (off < 16'hf) begin
          words[off[3:0]] <= word_data_q;
        end
      end
    end
  end
endmodule // eiw_cpu_model

/* File: testbench.sv */
// Self-checking bench for the encoder input word table.
// Assumes short ms (CPM cycles) and that the model reads each sweep.
`timescale 1ns/1ps
module testbench;
  localparam CPM = 10;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sweep_start = 1'b0;
  logic [15:0] cfg_base_addr = 16'h0100;
  logic        quadrature_counter_mode = 1'b0;
  logic [15:0] cfg_timebase_ms = 16'h0002;
  logic [15:0] enc_gray_pin = 16'h0000;
  logic        home_marker_pin = 1'b0;
  logic        abs_fault_pin = 1'b0;
  logic [3:0]  strobe_pin = 4'h0;
  logic [3:0]  strobe_clear = 4'h0;
  logic        preload_cmd = 1'b0;
  logic [31:0] preload_value = 32'h0;
  logic [5:0]  err_p = 6'h0;
  logic [7:0]  preset_num = 8'h9c;
  logic        error_clear = 1'b0;
  logic [15:0] compare_states = 16'ha5c3;
  logic        jam = 1'b0;
  logic        run = 1'b0;
  logic [31:0] stp = 32'h0;
  logic [1:0]  div = 2'h0;
  // Up-count phase order; jam flips both phases at once
  wire         quad_a_pin = stp[1] ^ jam;
  wire         quad_b_pin = stp[1] ^ stp[0] ^ jam;
  wire         word_valid_q, sweep_busy_q, error_flag_q;
  wire  [15:0] word_addr_q, word_data_q;
  logic [15:0] words [0:14];
  logic [4:0]  n_words;
  logic        addr_bad;
  int          error_cnt = 0;
  int          check_count = 0;

  eiw_table #(.CLK_PER_MS(CPM), .ENC_W(16)) u_eiw_table (
    .core_clk, .resetn, .sweep_start, .cfg_base_addr, .quadrature_counter_mode,
    .cfg_timebase_ms, .enc_gray_pin, .quad_a_pin, .quad_b_pin, .home_marker_pin,
    .abs_fault_pin, .strobe_pin, .strobe_clear, .preload_cmd, .preload_value,
    .offset_bad(err_p[0]), .on_preset_bad(err_p[1]), .off_preset_bad(err_p[2]),
    .preset_num, .home_pos_bad(err_p[3]), .preload_pos_bad(err_p[4]),
    .home_fsm_bad(err_p[5]), .error_clear, .compare_states, .word_valid_q,
    .word_addr_q, .word_data_q, .sweep_busy_q, .error_flag_q);
  eiw_cpu_model u_eiw_cpu_model (.core_clk, .resetn, .base(cfg_base_addr),
    .word_valid_q, .word_addr_q, .word_data_q, .words, .n_words, .addr_bad);

  always #2 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    if (run) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        stp <= stp + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    tick(1);
  endtask
  task automatic fire(input int k);
    err_p[k] = 1'b1;
    tick(1);
    err_p = 6'h0;
  endtask
  task automatic pulse_clear;
    error_clear = 1'b1;
    tick(1);
    error_clear = 1'b0;
    tick(2);
  endtask
  task automatic sweep(input logic again);
    int i;
    sweep_start = 1'b1;
    tick(1);
    sweep_start = 1'b0;
    if (again) begin
      tick(4);
      sweep_start = 1'b1;
      tick(1);
      sweep_start = 1'b0;
    end
    i = 0;
    while (i < 3 || sweep_busy_q !== 1'b0 || word_valid_q !== 1'b0) begin
      tick(1);
      i++;
      if (i > 40) begin
        error_cnt++;
        $display("mismatch %0t sweep never ended", $time);
        close_out();
      end
    end
    chk(n_words, 32'hf);
    chk(addr_bad, 32'h0);
  endtask
  function automatic logic [15:0] g2b(input logic [15:0] g);
    int j;
    g2b[15] = g[15];
    for (j = 14; j >= 0; j--)
      g2b[j] = g2b[j + 1] ^ g[j];
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_words;
    sweep(1'b0);
    chk(words[0], 32'h0);
    chk({words[5], words[4]}, 32'h0);
    chk(words[12], 32'ha5c3);
    chk({words[14], words[13]}, 32'h0);
    cfg_base_addr = 16'hfff8;
    compare_states = 16'h5a3c;
    sweep(1'b1);
    chk(words[12], 32'h5a3c);
  endtask
  task automatic t_errors;
    logic [15:0] exp [0:5];
    logic [5:0]  md;
    int i;
    exp = '{16'h0010, 16'h9c11, 16'h9c12, 16'h0015, 16'h0016, 16'h001c};
    md = 6'b111010;
    for (i = 0; i < 6; i++) begin
      quadrature_counter_mode = md[i];
      tick(3);
      fire(i);
      chk(error_flag_q, 32'h1);
      fire(i == 1 ? 2 : 1);
      sweep(1'b0);
      chk(words[0], exp[i]);
      pulse_clear();
      sweep(1'b0);
      chk(words[0], 32'h0);
      if (i == 0 || i > 2) begin
        quadrature_counter_mode = ~md[i];
        tick(3);
        fire(i);
        chk(error_flag_q, 32'h0);
      end
    end
  endtask
  task automatic t_pin_errors;
    quadrature_counter_mode = 1'b0;
    abs_fault_pin = 1'b1;
    tick(6);
    abs_fault_pin = 1'b0;
    tick(4);
    sweep(1'b0);
    chk(words[0], 32'h1d);
    pulse_clear();
    quadrature_counter_mode = 1'b1;
    tick(4);
    jam = ~jam;
    tick(6);
    sweep(1'b0);
    chk(words[0], 32'h1e);
    pulse_clear();
    chk(error_flag_q, 32'h0);
  endtask
  task automatic t_abs_words;
    logic [15:0] g [0:2];
    logic [15:0] cap;
    int i, k;
    g = '{16'h8001, 16'h1234, 16'hffff};
    quadrature_counter_mode = 1'b0;
    for (i = 0; i < 3; i++) begin
      strobe_pin = 4'h0;
      tick(4);
      if (i == 2) begin
        strobe_clear = 4'hf;
        tick(1);
        strobe_clear = 4'h0;
      end
      enc_gray_pin = g[i];
      tick(6);
      if (i != 1) begin
        cap = g2b(g[i]);
      end
      strobe_pin = 4'hf;
      tick(6);
      sweep(1'b0);
      chk(words[2], g[i]);
      chk(words[3], g2b(g[i]));
      for (k = 0; k < 4; k++)
        chk(words[6 + k], cap);
    end
    quadrature_counter_mode = 1'b1;
    tick(4);
    sweep(1'b0);
    chk(words[2], 32'h0);
  endtask
  task automatic t_quad_count;
    logic [31:0] s0;
    do_reset();
    tick(6);
    s0 = stp;
    run = 1'b1;
    tick(80);
    sweep(1'b0);
    chk(words[1], 32'h5);
    run = 1'b0;
    tick(20);
    sweep(1'b0);
    chk(words[3], stp - s0);
    chk({words[5], words[4]}, stp - s0);
    home_marker_pin = 1'b1;
    tick(6);
    sweep(1'b0);
    chk({words[5], words[4]}, 32'h0);
    chk(words[3], 32'h0);
    preload_value = 32'h8001_2345;
    preload_cmd = 1'b1;
    tick(1);
    preload_cmd = 1'b0;
    tick(2);
    sweep(1'b0);
    chk({words[5], words[4]}, 32'h8001_2345);
    cfg_timebase_ms = 16'h0;
    run = 1'b1;
    tick(22000);
    sweep(1'b0);
    chk(words[1], 32'h9c4);
    run = 1'b0;
  endtask

  initial begin
    do_reset();
    t_reset_words();
    t_errors();
    t_pin_errors();
    t_abs_words();
    t_quad_count();
    close_out();
  end
endmodule // testbench
